/* assp_buf.sv */
// two-entry buffer with valid and ready on both sides
// assumes one clock, asynchronous active-low reset
`timescale 1ns/1ps
module assp_buf #(
  parameter int W = 9
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  logic [W-1:0] mem [2];
  logic         wr_ptr;
  logic         rd_ptr;
  logic [1:0]   fill;
  wire          push = in_valid && in_ready;
  wire          pop  = out_valid && out_ready;

  assign in_ready  = fill != 2'h2;
  assign out_valid = fill != 2'h0;
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mem[0] <= '0;
      mem[1] <= '0;
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      fill   <= 2'h0;
    end else if (clk_en) begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr      <= !wr_ptr;
      end
      if (pop)
        rd_ptr <= !rd_ptr;
      fill <= fill + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : assp_buf

/* assp_host.sv */
// host controller model on the shared two-wire bus
// assumes the bench resolves the bus and biases it high when released
`timescale 1ns/1ps
module assp_host (
  input  wire logic        clk,
  input  wire logic [15:0] bit_cyc,
  input  wire logic        bus,
  output logic             host_tx,
  output logic             host_oe
);
  // ------------------------------------------------------------
  // transmit side
  // ------------------------------------------------------------
  logic [7:0] rxq[$];
  logic [7:0] sh;
  int         frame_bad = 0;
  initial begin
    host_tx = 1'b1;
    host_oe = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n * bit_cyc) @(negedge clk);
  endtask : hold
  // one character, stop level chosen by caller
  task automatic send(input logic [7:0] b, input logic stop);
    host_oe = 1'b1;
    host_tx = 1'b0;
    hold(1);
    for (int i = 0; i < 8; i++) begin
      host_tx = b[i];
      hold(1);
    end
    host_tx = stop;
    hold(1);
    host_tx = 1'b1;
    host_oe = 1'b0;
  endtask : send
  // low pulse shorter than half a bit
  task automatic glitch();
    host_oe = 1'b1;
    host_tx = 1'b0;
    repeat (bit_cyc / 4) @(negedge clk);
    host_tx = 1'b1;
    host_oe = 1'b0;
  endtask : glitch
  // ------------------------------------------------------------
  // receive side, listens only while released
  // ------------------------------------------------------------
  always begin
    @(negedge clk);
    if (!host_oe && !bus) begin
      repeat (bit_cyc / 2) @(negedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (bit_cyc) @(negedge clk);
        sh[i] = bus;
      end
      repeat (bit_cyc) @(negedge clk);
      if (!bus) frame_bad++;
      rxq.push_back(sh);
    end
  end
endmodule : assp_host

/* assp_pkg.sv */
// constants and types shared by the addressed serial slave port
// assumes a single 100 MHz clock domain
// Behaviour
// - every character is one start bit, eight data bits, one stop bit
// - data bits travel least significant bit first as plain binary
// - bit rate selectable at 4800, 9600 or 19200 baud
// - own station address must lie between 1 and 247
// - address 0 is broadcast to all stations, never an own address
// - line driver enabled only while sending, released otherwise
// - messages framed by at least 3.5 character times of silence
// - first character after silence is address; act only on clean matching messages
// - broadcast messages are delivered but never answered
// - reply starts with own station address
package assp_pkg;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ   = 100_000_000;
  localparam int unsigned BAUD_LO  = 4800;
  localparam int unsigned BAUD_MID = 9600;
  localparam int unsigned BAUD_HI  = 19200;
  localparam int          CNT_W    = 15;
  // 3.5 characters of 10 bits each
  localparam logic [5:0]  SIL_BITS = 6'h23;
  localparam logic [2:0]  LAST_BIT = 3'h7;
  // ------------------------------------------------------------
  // configuration codes
  // ------------------------------------------------------------
  localparam logic [1:0]  RATE_LO    = 2'h0;
  localparam logic [1:0]  RATE_MID   = 2'h1;
  localparam logic [1:0]  RATE_HI    = 2'h2;
  localparam logic [7:0]  ADDR_BCAST = 8'h00;
  localparam logic [7:0]  ADDR_MIN   = 8'h01;
  localparam logic [7:0]  ADDR_MAX   = 8'hf7;
  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_START = 2'b01,
    S_DATA  = 2'b11,
    S_STOP  = 2'b10
  } assp_ser_e;
endpackage : assp_pkg

/* assp_port.sv */
// half-duplex addressed serial slave port: receiver, silence framing,
// address filter and reply transmitter
// assumes line_rx is asynchronous; config inputs are on clk
`timescale 1ns/1ps
module assp_port
  import assp_pkg::*;
#(
  parameter int unsigned BIT_LO_CYC  = CLK_HZ / BAUD_LO,
  parameter int unsigned BIT_MID_CYC = CLK_HZ / BAUD_MID,
  parameter int unsigned BIT_HI_CYC  = CLK_HZ / BAUD_HI
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       clk_en,
  input  wire logic [1:0] cfg_rate,
  input  wire logic [7:0] cfg_addr,
  input  wire logic       line_rx,
  output logic            line_tx,
  output logic            line_oe_n,
  output logic [7:0]      rx_data,
  output logic            rx_first,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  output logic            msg_done,
  output logic            msg_err,
  output logic            msg_bcast,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready
);
  // ------------------------------------------------------------
  // bit timing
  // ------------------------------------------------------------
  localparam logic [CNT_W-1:0] CYC_LO  = CNT_W'(BIT_LO_CYC);
  localparam logic [CNT_W-1:0] CYC_MID = CNT_W'(BIT_MID_CYC);
  localparam logic [CNT_W-1:0] CYC_HI  = CNT_W'(BIT_HI_CYC);

  wire [CNT_W-1:0] bit_cyc = (cfg_rate == RATE_HI)  ? CYC_HI :
                             (cfg_rate == RATE_MID) ? CYC_MID : CYC_LO;
  wire [CNT_W-1:0] bit_rld = bit_cyc - 1'b1;
  wire [CNT_W-1:0] half    = bit_cyc >> 1;

  // ------------------------------------------------------------
  // receiver
  // ------------------------------------------------------------
  logic             rx_m;
  logic             rx_s;
  assp_ser_e        rx_st;
  logic [CNT_W-1:0] rx_cnt;
  logic [2:0]       rx_idx;
  logic [7:0]       rx_sh;
  assp_ser_e        tx_st;
  logic [CNT_W-1:0] tx_cnt;
  logic [2:0]       tx_idx;
  logic [7:0]       tx_sh;
  logic             in_reply;
  logic             reply_ok;
  logic             bcast_drop;
  logic [5:0]       sil_cnt;
  logic [CNT_W-1:0] sil_tmr;
  logic             msg_open;
  logic             msg_match;
  logic             msg_bad;
  logic             buf_in_ready;

  wire rx_tick = rx_cnt == '0;
  wire rx_done = rx_st == S_STOP && rx_tick;
  wire tx_tick = tx_cnt == '0;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_m <= 1'b1;
      rx_s <= 1'b1;
    end else if (clk_en) begin
      rx_m <= line_rx;
      rx_s <= rx_m;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_st  <= S_IDLE;
      rx_cnt <= '0;
      rx_idx <= 3'h0;
      rx_sh  <= 8'h00;
    end else if (clk_en) begin
      rx_cnt <= rx_tick ? bit_rld : rx_cnt - 1'b1;
      case (rx_st)
        S_IDLE: begin
          if (line_oe_n && !rx_s) begin
            rx_st  <= S_START;
            rx_cnt <= half;
          end
        end
        S_START: begin
          if (rx_tick) begin
            rx_st  <= rx_s ? S_IDLE : S_DATA;
            rx_idx <= 3'h0;
          end
        end
        S_DATA: begin
          if (rx_tick) begin
            rx_sh  <= {rx_s, rx_sh[7:1]};
            rx_idx <= rx_idx + 3'h1;
            if (rx_idx == LAST_BIT)
              rx_st <= S_STOP;
          end
        end
        S_STOP: begin
          if (rx_tick)
            rx_st <= S_IDLE;
        end
        default: rx_st <= S_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // silence framing and address filter
  // ------------------------------------------------------------
  wire quiet    = rx_st == S_IDLE && rx_s && tx_st == S_IDLE;
  wire silent   = sil_cnt == SIL_BITS;
  wire addr_ok  = cfg_addr >= ADDR_MIN && cfg_addr <= ADDR_MAX;
  wire hit_bc   = rx_sh == ADDR_BCAST;
  wire hit_own  = addr_ok && rx_sh == cfg_addr;
  wire first_ch = rx_done && !msg_open;
  wire ch_match = msg_open ? msg_match : (hit_own || hit_bc);
  wire buf_in_v = rx_done && rx_s && ch_match && (first_ch || !msg_bad);
  wire ch_bad   = !rx_s || (buf_in_v && !buf_in_ready);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sil_cnt <= SIL_BITS;
      sil_tmr <= '0;
    end else if (clk_en) begin
      if (!quiet) begin
        sil_cnt <= 6'h00;
        sil_tmr <= bit_rld;
      end else if (!silent) begin
        sil_tmr <= (sil_tmr == '0) ? bit_rld : sil_tmr - 1'b1;
        if (sil_tmr == '0)
          sil_cnt <= sil_cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      msg_open  <= 1'b0;
      msg_match <= 1'b0;
      msg_bcast <= 1'b0;
      msg_bad   <= 1'b0;
      msg_done  <= 1'b0;
      msg_err   <= 1'b0;
    end else if (clk_en) begin
      msg_done <= 1'b0;
      msg_err  <= 1'b0;
      if (first_ch) begin
        msg_open  <= 1'b1;
        msg_match <= hit_own || hit_bc;
        msg_bcast <= hit_bc;
        msg_bad   <= ch_bad;
      end else if (rx_done && ch_bad) begin
        msg_bad <= 1'b1;
      end else if (msg_open && silent) begin
        msg_open <= 1'b0;
        msg_done <= msg_match && !msg_bad;
        msg_err  <= msg_match && msg_bad;
      end
    end
  end

  assp_buf #(.W(9)) u_rx_buf (
    .clk       (clk),
    .reset_n   (reset_n),
    .clk_en    (clk_en),
    .in_data   ({first_ch, rx_sh}),
    .in_valid  (buf_in_v),
    .in_ready  (buf_in_ready),
    .out_data  ({rx_first, rx_data}),
    .out_valid (rx_valid),
    .out_ready (rx_ready)
  );

  // ------------------------------------------------------------
  // reply transmitter
  // ------------------------------------------------------------
  wire tx_idle  = tx_st == S_IDLE;
  wire rep_go   = tx_idle && !in_reply && reply_ok && silent && !msg_open && tx_valid;
  wire rep_next = tx_idle && in_reply && tx_valid;
  wire rep_end  = tx_idle && in_reply && !tx_valid;
  wire [7:0] tx_byte = rep_go ? cfg_addr : tx_data;

  assign tx_ready  = rep_next || bcast_drop;
  assign line_oe_n = tx_idle && !in_reply;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reply_ok   <= 1'b0;
      bcast_drop <= 1'b0;
      in_reply   <= 1'b0;
    end else if (clk_en) begin
      if (first_ch || rep_end) begin
        reply_ok   <= 1'b0;
        bcast_drop <= 1'b0;
      end else if (msg_done) begin
        reply_ok   <= !msg_bcast;
        bcast_drop <= msg_bcast;
      end
      if (rep_go)
        in_reply <= 1'b1;
      else if (rep_end)
        in_reply <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_st   <= S_IDLE;
      tx_cnt  <= '0;
      tx_idx  <= 3'h0;
      tx_sh   <= 8'h00;
      line_tx <= 1'b1;
    end else if (clk_en) begin
      tx_cnt <= tx_tick ? bit_rld : tx_cnt - 1'b1;
      case (tx_st)
        S_IDLE: begin
          line_tx <= 1'b1;
          if (rep_go || rep_next) begin
            tx_st   <= S_START;
            tx_sh   <= tx_byte;
            tx_cnt  <= bit_rld;
            line_tx <= 1'b0;
          end
        end
        S_START: begin
          if (tx_tick) begin
            tx_st   <= S_DATA;
            tx_idx  <= 3'h0;
            line_tx <= tx_sh[0];
          end
        end
        S_DATA: begin
          if (tx_tick) begin
            tx_idx <= tx_idx + 3'h1;
            tx_sh  <= tx_sh >> 1;
            if (tx_idx == LAST_BIT) begin
              tx_st   <= S_STOP;
              line_tx <= 1'b1;
            end else begin
              line_tx <= tx_sh[1];
            end
          end
        end
        S_STOP: begin
          if (tx_tick)
            tx_st <= S_IDLE;
        end
        default: tx_st <= S_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_bad_stop;
    clk_en && rx_done && !rx_s;
  endsequence
  sequence s_rep_start;
    clk_en && rep_go;
  endsequence

  property p_start_low;
    tx_st == S_START |-> !line_tx && !line_oe_n;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not low");
  property p_stop_high;
    tx_st == S_STOP |-> line_tx;
  endproperty
  a_stop_high: assert property (p_stop_high) else $error("stop bit not high");
  property p_lsb_first;
    clk_en && tx_st == S_DATA && tx_tick && tx_idx != LAST_BIT |=> line_tx == $past(tx_sh[1]);
  endproperty
  a_lsb_first: assert property (p_lsb_first) else $error("bit order wrong");
  property p_rate;
    tx_st != S_IDLE |-> tx_cnt <= bit_rld;
  endproperty
  a_rate: assert property (p_rate) else $error("bit counter beyond rate");
  property p_own_range;
    buf_in_v && !msg_open && !hit_bc |-> addr_ok && rx_sh == cfg_addr;
  endproperty
  a_own_range: assert property (p_own_range) else $error("bad own address accepted");
  property p_bcast;
    clk_en && first_ch && rx_s && hit_bc |=> msg_bcast && msg_match;
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast not recognised");
  property p_release;
    tx_idle && !in_reply |-> line_oe_n;
  endproperty
  a_release: assert property (p_release) else $error("driver on while idle");
  property p_gap;
    s_rep_start |-> sil_cnt == SIL_BITS;
  endproperty
  a_gap: assert property (p_gap) else $error("reply without silence");
  property p_filter;
    buf_in_v |-> ch_match && (first_ch || !msg_bad) && rx_s;
  endproperty
  a_filter: assert property (p_filter) else $error("unmatched byte delivered");
  property p_no_bc_reply;
    !line_oe_n |-> !msg_bcast;
  endproperty
  a_no_bc_reply: assert property (p_no_bc_reply) else $error("broadcast answered");
  property p_addr_first;
    s_rep_start |=> tx_sh == $past(cfg_addr) ##1 tx_st == S_START;
  endproperty
  a_addr_first: assert property (p_addr_first) else $error("reply lacks own address");
  property p_ferr;
    s_bad_stop |=> msg_bad;
  endproperty
  a_ferr: assert property (p_ferr) else $error("framing error missed");
endmodule : assp_port

/* assp_port_tb.sv */
// self-checking bench for the addressed serial slave port
// assumes assp_host as the far side of the bus
`timescale 1ns/1ps
module assp_port_tb;
  import assp_pkg::*;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        clk_en = 1'b1;
  logic [1:0]  cfg_rate = RATE_HI;
  logic [7:0]  cfg_addr = 8'h2a;
  logic        rx_ready = 1'b1;
  logic [7:0]  tx_data = 8'h00;
  logic        tx_valid = 1'b0;
  logic        line_tx, line_oe_n, rx_first, rx_valid, msg_done, msg_err;
  logic        msg_bcast, tx_ready, host_tx, host_oe;
  logic [7:0]  rx_data;
  logic [15:0] bit_cyc;
  logic [8:0]  rxs[$];
  int          failures = 0;
  int          n_compared = 0;
  int          n_done = 0;
  int          n_err = 0;
  int          oe_cyc = 0;
  wire         bus;
  // ------------------------------------------------------------
  // bus, clock, instances
  // ------------------------------------------------------------
  assign bus = !line_oe_n ? line_tx : (host_oe ? host_tx : 1'b1);
  assign bit_cyc = cfg_rate == RATE_MID ? 16'h000c :
                   cfg_rate == RATE_HI ? 16'h0008 : 16'h0010;
  always #5 clk = ~clk;
  assp_port #(.BIT_LO_CYC(16), .BIT_MID_CYC(12), .BIT_HI_CYC(8)) u_dut (
    .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .cfg_rate(cfg_rate),
    .cfg_addr(cfg_addr), .line_rx(bus), .line_tx(line_tx), .line_oe_n(line_oe_n),
    .rx_data(rx_data), .rx_first(rx_first), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .msg_done(msg_done), .msg_err(msg_err), .msg_bcast(msg_bcast),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
  assp_host u_host (.clk(clk), .bit_cyc(bit_cyc), .bus(bus), .host_tx(host_tx),
    .host_oe(host_oe));
  always @(posedge clk) begin
    if (msg_done) n_done++;
    if (msg_err) n_err++;
    if (rx_valid && rx_ready) rxs.push_back({rx_first, rx_data});
    if (!line_oe_n) oe_cyc++;
    if (!line_oe_n && host_oe) chk(16'h1, 16'h0);
  end
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("compared %0d mismatched %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  task automatic wait_end();
    int k;
    k = n_done + n_err;
    for (int i = 0; i < 1000 && n_done + n_err == k; i++) @(negedge clk);
    if (n_done + n_err == k) begin
      chk(16'h0, 16'h1);
      end_of_test();
    end
  endtask : wait_end
  task automatic msg(input logic [7:0] a, input logic [7:0] b, input logic stop,
                     input int gap);
    rxs.delete();
    oe_cyc = 0;
    u_host.hold(36);
    u_host.send(a, 1'b1);
    u_host.hold(gap);
    u_host.send(b, stop);
  endtask : msg
  task automatic reply(input logic [7:0] a, input logic [7:0] b);
    int   n;
    logic took;
    n = 0;
    took = 1'b0;
    tx_data = a;
    tx_valid = 1'b1;
    for (int k = 0; k < 5000 && n < 2; k++) begin
      @(negedge clk);
      if (took) begin
        n++;
        tx_data = b;
      end
      took = tx_ready;
    end
    tx_valid = 1'b0;
    if (n < 2) begin
      chk(16'(n), 16'h2);
      end_of_test();
    end
  endtask : reply
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_unicast();
    logic [7:0] adr[4] = '{8'h01, 8'hf7, 8'h2a, 8'h80};
    int         d;
    for (int r = 0; r < 4; r++) begin
      cfg_rate = 2'(r);
      cfg_addr = adr[r];
      d = n_done;
      u_host.rxq.delete();
      msg(adr[r], 8'h03, 1'b1, 20);
      u_host.send(8'h5a, 1'b1);
      wait_end();
      chk(16'(n_done - d), 16'h1);
      chk(16'(rxs[0]), {8'h01, adr[r]});
      chk(16'(rxs[1]), 16'h0003);
      chk(16'(rxs[2]), 16'h005a);
      chk({15'h0, msg_bcast}, 16'h0);
      reply(8'h11, 8'h8c);
      for (int i = 0; i < 3000 && u_host.rxq.size() < 3; i++) @(negedge clk);
      if (u_host.rxq.size() < 3) begin
        chk(16'(u_host.rxq.size()), 16'h3);
        end_of_test();
      end
      chk(16'(u_host.rxq[0]), {8'h00, adr[r]});
      chk(16'(u_host.rxq[1]), 16'h0011);
      chk(16'(u_host.rxq[2]), 16'h008c);
      chk(16'(u_host.frame_bad), 16'h0);
      repeat (bit_cyc) @(negedge clk);
      chk({15'h0, line_oe_n}, 16'h1);
    end
    $display("t_unicast done");
  endtask : t_unicast
  task automatic t_bcast();
    msg(ADDR_BCAST, 8'h06, 1'b1, 0);
    wait_end();
    chk({15'h0, msg_bcast}, 16'h1);
    chk(16'(rxs[0]), 16'h0100);
    tx_data = 8'h77;
    tx_valid = 1'b1;
    u_host.hold(50);
    tx_valid = 1'b0;
    chk(16'(oe_cyc), 16'h0);
    $display("t_bcast done");
  endtask : t_bcast
  task automatic t_foreign();
    int d;
    d = n_done + n_err;
    tx_valid = 1'b1;
    msg(8'h05, 8'h03, 1'b1, 0);
    u_host.hold(45);
    tx_valid = 1'b0;
    chk(16'(rxs.size()), 16'h0);
    chk(16'(n_done + n_err - d), 16'h0);
    chk(16'(oe_cyc), 16'h0);
    $display("t_foreign done");
  endtask : t_foreign
  task automatic t_frame();
    int d;
    int e;
    d = n_done;
    e = n_err;
    u_host.glitch();
    msg(cfg_addr, 8'h10, 1'b0, 0);
    wait_end();
    chk(16'(n_err - e), 16'h1);
    chk(16'(n_done - d), 16'h0);
    chk(16'(rxs[0]), {8'h01, cfg_addr});
    $display("t_frame done");
  endtask : t_frame
  task automatic t_overrun();
    int e;
    e = n_err;
    rx_ready = 1'b0;
    msg(cfg_addr, 8'ha1, 1'b1, 0);
    u_host.send(8'ha2, 1'b1);
    wait_end();
    chk(16'(n_err - e), 16'h1);
    chk({15'h0, rx_valid}, 16'h1);
    rx_ready = 1'b1;
    repeat (4) @(negedge clk);
    chk(16'(rxs.size()), 16'h2);
    chk(16'(rxs[1]), 16'h00a1);
    chk({15'h0, rx_valid}, 16'h0);
    $display("t_overrun done");
  endtask : t_overrun
  task automatic t_freeze();
    int d;
    msg(ADDR_BCAST, 8'h06, 1'b1, 0);
    wait_end();
    d = n_done + n_err;
    clk_en = 1'b0;
    msg(cfg_addr, 8'h42, 1'b1, 0);
    u_host.hold(40);
    chk({15'h0, msg_bcast}, 16'h1);
    chk(16'(n_done + n_err - d), 16'h0);
    chk(16'(rxs.size()), 16'h0);
    clk_en = 1'b1;
    reset_n = 1'b0;
    repeat (3) @(negedge clk);
    chk({15'h0, msg_bcast}, 16'h0);
    chk({15'h0, line_oe_n}, 16'h1);
    reset_n = 1'b1;
    msg(cfg_addr, 8'h24, 1'b1, 0);
    wait_end();
    chk(16'(rxs[0]), {8'h01, cfg_addr});
    chk(16'(rxs[1]), 16'h0024);
    $display("t_freeze done");
  endtask : t_freeze
  initial begin
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    t_unicast();
    t_bcast();
    t_foreign();
    t_frame();
    t_overrun();
    t_freeze();
    end_of_test();
  end
endmodule : assp_port_tb
